/* File: rtl/dsl_matrix.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module dsl_matrix
(
    input  logic        clk_sys,
    input  logic        resetn,
    input  logic [7:0]  addr,
    input  logic [31:0] wdata,
    input  logic        wr_en,
    input  logic        rd_en,
    output logic [31:0] rdata_q,
    input  logic [7:0]  din_pin,
    input  logic [15:0] func_in,
    output logic [7:0]  din_eff_q,
    output logic [7:0]  dout_q,
    output logic [7:0]  isig_q
);

    logic [15:0]        din_ovr_q;
    logic [15:0]        dout_mod_q;
    logic [31:0]        dout_src_q;
    logic [15:0]        isig_mod_q;
    logic [31:0]        isig_src_q;
    dsl_pkg::slot_t     slot_q [dsl_pkg::NSLOT];
    logic [7:0]         din_eff;
    logic [7:0]         dout_fn;
    logic [7:0]         isig_fn;
    logic [7:0]         dout_d;
    logic [7:0]         isig_d;
    logic [3:0]         slot_on;
    logic [3:0]         slot_res;
    logic [3:0]         op1;
    logic [3:0]         op2;
    logic [4:0]         di;
    logic [31:0]        rdata_d;

    function automatic logic apply_mode
    (
        input logic [1:0] m,
        input logic       f,
        input logic       inv_ok
    );
        logic r;
        r = f;
        unique case (m)
            dsl_pkg::M_HIGH:   r = 1'b1;
            dsl_pkg::M_LOW:    r = 1'b0;
            dsl_pkg::M_INV:    r = inv_ok ? !f : f;
            dsl_pkg::M_FOLLOW: r = f;
        endcase
        return r;
    endfunction

    // Operand sources: 1..8 digital inputs, 9..16 internal signals
    function automatic logic pick
    (
        input logic [4:0] s,
        input logic [7:0] dv,
        input logic [7:0] iv
    );
        logic [4:0] k;
        logic       r;
        r = 1'b0;
        k = 5'h00;
        if (s >= dsl_pkg::SEL_DIO && s < dsl_pkg::SEL_IS)
        begin
            k = s - dsl_pkg::SEL_DIO;
            r = dv[k[2:0]];
        end
        else if (s >= dsl_pkg::SEL_IS && s <= dsl_pkg::SEL_LAST)
        begin
            k = s - dsl_pkg::SEL_IS;
            r = iv[k[2:0]];
        end
        return r;
    endfunction

    function automatic logic slot_eval
    (
        input dsl_pkg::slot_t c,
        input logic           a,
        input logic           b
    );
        logic r;
        r = 1'b0;
        unique case (c.fn)
            dsl_pkg::F_AND: r = a & b;
            dsl_pkg::F_OR:  r = a | b;
            dsl_pkg::F_XOR: r = a ^ b;
            dsl_pkg::F_NOT: r = !a;
            default:        r = 1'b0;
        endcase
        return r ^ c.invr;
    endfunction

    // Configuration writes
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            din_ovr_q  <= dsl_pkg::CFG_RST[15:0];
            dout_mod_q <= dsl_pkg::CFG_RST[15:0];
            dout_src_q <= dsl_pkg::CFG_RST;
            isig_mod_q <= dsl_pkg::CFG_RST[15:0];
            isig_src_q <= dsl_pkg::CFG_RST;
        end
        else if (wr_en)
        begin
            unique case (addr)
                dsl_pkg::A_DIN_OVR:  din_ovr_q  <= wdata[15:0];
                dsl_pkg::A_DOUT_MOD: dout_mod_q <= wdata[15:0];
                dsl_pkg::A_DOUT_SRC: dout_src_q <= wdata;
                dsl_pkg::A_ISIG_MOD: isig_mod_q <= wdata[15:0];
                dsl_pkg::A_ISIG_SRC: isig_src_q <= wdata;
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            for (int s = 0; s < dsl_pkg::NSLOT; s++)
            begin
                slot_q[s] <= dsl_pkg::CFG_RST[20:0];
            end
        end
        else if (wr_en && addr[7:4] == dsl_pkg::SLOT_PAGE && addr[1:0] == 2'h0)
        begin
            slot_q[addr[3:2]] <= wdata[20:0];
        end
    end

    // Inputs are combinational so a pin change reaches outputs in one clock
    always_comb
    begin
        din_eff = '0;
        for (int k = 0; k < dsl_pkg::NDI; k++)
        begin
            din_eff[k] = apply_mode(din_ovr_q[2*k +: 2], din_pin[k], 1'b0);
        end
    end

    // Internal signals enter as registered values, which breaks loops
    // through slots that feed internal signals back to themselves.
    for (genvar s = 0; s < dsl_pkg::NSLOT; s++)
    begin : g_slot
        assign op1[s] = pick(slot_q[s].src1, din_eff, isig_q)
                        ^ (slot_q[s].inv1 & (slot_q[s].src1 != dsl_pkg::SEL_NONE));
        assign op2[s] = pick(slot_q[s].src2, din_eff, isig_q)
                        ^ (slot_q[s].inv2 & (slot_q[s].src2 != dsl_pkg::SEL_NONE));
        assign slot_on[s] = (slot_q[s].fn >= dsl_pkg::F_AND)
                            && (slot_q[s].fn <= dsl_pkg::F_NOT)
                            && (slot_q[s].dst != dsl_pkg::SEL_NONE)
                            && (slot_q[s].dst <= dsl_pkg::SEL_LAST);
        assign slot_res[s] = slot_eval(slot_q[s], op1[s], op2[s]);
    end

    // Function source, then slots in order; a later slot wins a shared target
    always_comb
    begin
        dout_fn = '0;
        isig_fn = '0;
        di = 5'h00;
        for (int k = 0; k < dsl_pkg::NDO; k++)
        begin
            dout_fn[k] = func_in[dout_src_q[4*k +: 4]];
        end
        for (int k = 0; k < dsl_pkg::NIS; k++)
        begin
            isig_fn[k] = func_in[isig_src_q[4*k +: 4]];
        end
        for (int s = 0; s < dsl_pkg::NSLOT; s++)
        begin
            if (slot_on[s])
            begin
                if (slot_q[s].dst < dsl_pkg::SEL_IS)
                begin
                    di = slot_q[s].dst - dsl_pkg::SEL_DIO;
                    dout_fn[di[2:0]] = slot_res[s];
                end
                else
                begin
                    di = slot_q[s].dst - dsl_pkg::SEL_IS;
                    isig_fn[di[2:0]] = slot_res[s];
                end
            end
        end
    end

    always_comb
    begin
        dout_d = '0;
        isig_d = '0;
        for (int k = 0; k < dsl_pkg::NDO; k++)
        begin
            dout_d[k] = apply_mode(dout_mod_q[2*k +: 2], dout_fn[k], 1'b1);
        end
        for (int k = 0; k < dsl_pkg::NIS; k++)
        begin
            isig_d[k] = apply_mode(isig_mod_q[2*k +: 2], isig_fn[k], 1'b0);
        end
    end

    // Every output is refreshed each clock
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            din_eff_q <= 8'h00;
            dout_q    <= 8'h00;
            isig_q    <= 8'h00;
        end
        else
        begin
            din_eff_q <= din_eff;
            dout_q    <= dout_d;
            isig_q    <= isig_d;
        end
    end

    // Read decode
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (addr[7:4] == dsl_pkg::SLOT_PAGE && addr[1:0] == 2'h0)
        begin
            rdata_d[20:0] = slot_q[addr[3:2]];
        end
        else
        begin
            unique case (addr)
                dsl_pkg::A_DIN_OVR:  rdata_d[15:0] = din_ovr_q;
                dsl_pkg::A_DOUT_MOD: rdata_d[15:0] = dout_mod_q;
                dsl_pkg::A_DOUT_SRC: rdata_d = dout_src_q;
                dsl_pkg::A_ISIG_MOD: rdata_d[15:0] = isig_mod_q;
                dsl_pkg::A_ISIG_SRC: rdata_d = isig_src_q;
                dsl_pkg::A_DIN_PIN:  rdata_d[7:0] = din_pin;
                dsl_pkg::A_STATE:    rdata_d[23:0] = {isig_q, dout_q, din_eff_q};
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rd_en ? rdata_d : 32'h0000_0000;
        end
    end

    din_high_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        din_ovr_q[3:2] == dsl_pkg::M_HIGH |=> din_eff_q[1])
        else $error("forced high input not active");

    din_low_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        din_ovr_q[1:0] == dsl_pkg::M_LOW |=> !din_eff_q[0])
        else $error("forced low input not inactive");

    din_follow_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        din_ovr_q[1:0] == dsl_pkg::M_FOLLOW |=> din_eff_q[0] == $past(din_pin[0]))
        else $error("following input differs from pin");

    dout_forced_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        dout_mod_q[1:0] == dsl_pkg::M_HIGH || dout_mod_q[1:0] == dsl_pkg::M_LOW
        |=> dout_q[0] == ($past(dout_mod_q[1:0]) == dsl_pkg::M_HIGH))
        else $error("forced output level wrong");

    dout_follow_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        dout_mod_q[3:2] == dsl_pkg::M_FOLLOW |=> dout_q[1] == $past(dout_fn[1]))
        else $error("following output differs from function");

    dout_inv_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        dout_mod_q[5:4] == dsl_pkg::M_INV |=> dout_q[2] != $past(dout_fn[2]))
        else $error("inverted output equals function");

    isig_forced_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        isig_mod_q[1:0] == dsl_pkg::M_HIGH ##1 isig_mod_q[1:0] == dsl_pkg::M_HIGH
        |-> isig_q[0])
        else $error("forced internal signal not active");

    isig_follow_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        isig_mod_q[1:0] == dsl_pkg::M_FOLLOW |=> isig_q[0] == $past(isig_fn[0]))
        else $error("following internal signal differs");

    slot_and_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_on[0] && slot_q[0].fn == dsl_pkg::F_AND && !slot_q[0].invr
        && slot_q[0].dst == dsl_pkg::SEL_DIO && slot_q[1].dst != dsl_pkg::SEL_DIO
        && slot_q[2].dst != dsl_pkg::SEL_DIO && slot_q[3].dst != dsl_pkg::SEL_DIO
        && dout_mod_q[1:0] == dsl_pkg::M_FOLLOW
        |=> dout_q[0] == ($past(op1[0]) & $past(op2[0])))
        else $error("AND slot result wrong");

    din_alt_follow_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        din_ovr_q[3:2] == dsl_pkg::M_INV |=> din_eff_q[1] == $past(din_pin[1]))
        else $error("spare input code does not follow pin");

    dout_low_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        dout_mod_q[3:2] == dsl_pkg::M_LOW |=> !dout_q[1])
        else $error("forced low output not inactive");

    isig_low_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        isig_mod_q[3:2] == dsl_pkg::M_LOW |=> !isig_q[1])
        else $error("forced low internal signal not inactive");

    isig_slot_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_on[0] && slot_q[0].dst == dsl_pkg::SEL_IS && slot_q[1].dst != dsl_pkg::SEL_IS
        && slot_q[2].dst != dsl_pkg::SEL_IS && slot_q[3].dst != dsl_pkg::SEL_IS
        && isig_mod_q[1:0] == dsl_pkg::M_FOLLOW
        |=> isig_q[0] == $past(slot_res[0]))
        else $error("slot result missing on internal signal");

    dest_unused_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].dst == dsl_pkg::SEL_NONE |-> !slot_on[0])
        else $error("slot without destination still drives");

    slot_negate_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].fn == dsl_pkg::F_AND && slot_q[0].invr |-> slot_res[0] == !(op1[0] & op2[0]))
        else $error("negated slot result wrong");

    op_negate_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].src1 == dsl_pkg::SEL_DIO |-> op1[0] == (din_eff[0] ^ slot_q[0].inv1))
        else $error("operand negate wrong");

    op_unused_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].src2 == dsl_pkg::SEL_NONE |-> !op2[0])
        else $error("unused operand contributes a level");

    slot_not_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].fn == dsl_pkg::F_NOT && !slot_q[0].invr |-> slot_res[0] == !op1[0])
        else $error("NOT slot result wrong");

    slot_or_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].fn == dsl_pkg::F_OR && !slot_q[0].invr |-> slot_res[0] == (op1[0] | op2[0]))
        else $error("OR slot result wrong");

    slot_xor_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].fn == dsl_pkg::F_XOR && !slot_q[0].invr |-> slot_res[0] == (op1[0] ^ op2[0]))
        else $error("XOR slot result wrong");

    slot_idle_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        slot_q[0].fn == dsl_pkg::F_NONE |-> !slot_on[0])
        else $error("slot without function still drives");

endmodule

/* File: rtl/dsl_pkg.sv */
package dsl_pkg;

    localparam int unsigned NDI   = 8;
    localparam int unsigned NDO   = 8;
    localparam int unsigned NIS   = 8;
    localparam int unsigned NFN   = 16;
    localparam int unsigned NSLOT = 4;

    localparam logic [7:0] A_DIN_OVR  = 8'h00;
    localparam logic [7:0] A_DOUT_MOD = 8'h04;
    localparam logic [7:0] A_DOUT_SRC = 8'h08;
    localparam logic [7:0] A_ISIG_MOD = 8'h0c;
    localparam logic [7:0] A_ISIG_SRC = 8'h10;
    localparam logic [7:0] A_DIN_PIN  = 8'h14;
    localparam logic [7:0] A_STATE    = 8'h18;
    localparam logic [3:0] SLOT_PAGE  = 4'h2;

    localparam logic [1:0] M_FOLLOW = 2'h0;
    localparam logic [1:0] M_HIGH   = 2'h1;
    localparam logic [1:0] M_LOW    = 2'h2;
    localparam logic [1:0] M_INV    = 2'h3;

    localparam logic [4:0] SEL_NONE = 5'h00;
    localparam logic [4:0] SEL_DIO  = 5'h01;
    localparam logic [4:0] SEL_IS   = 5'h09;
    localparam logic [4:0] SEL_LAST = 5'h10;

    localparam logic [2:0] F_NONE = 3'h0;
    localparam logic [2:0] F_AND  = 3'h1;
    localparam logic [2:0] F_OR   = 3'h2;
    localparam logic [2:0] F_XOR  = 3'h3;
    localparam logic [2:0] F_NOT  = 3'h4;

    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    typedef struct packed {
        logic       inv2;
        logic       inv1;
        logic       invr;
        logic [2:0] fn;
        logic [4:0] src2;
        logic [4:0] src1;
        logic [4:0] dst;
    } slot_t;

    localparam int unsigned SLOT_W = 21;

endpackage

/* File: test/field_side.sv */
`timescale 1ns/100ps
module field_side
(
    input  logic [7:0]  sw_cmd,
    input  logic [15:0] fn_cmd,
    input  logic [7:0]  load_drv,
    output logic [7:0]  din_pin,
    output logic [15:0] func_in,
    output logic [7:0]  load_on
);
    // Clean switch levels; contact bounce is left to the field wiring
    assign din_pin = sw_cmd;
    assign func_in = fn_cmd;
    // Loads simply follow the drive seen at the output pins
    assign load_on = load_drv;
endmodule

/* File: test/digital_signal_logic_matrix_tb.sv */
`timescale 1ns/100ps
module digital_signal_logic_matrix_tb;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [7:0]  din;
        logic [15:0] fn;
        logic [7:0]  ee;
        logic [7:0]  eo;
        logic [7:0]  ei;
    } row_t;

    logic           clk_sys;
    logic           resetn;
    logic [7:0]     addr;
    logic [31:0]    wdata;
    logic           wr_en;
    logic           rd_en;
    logic [31:0]    rdata_q;
    logic [7:0]     sw_cmd;
    logic [15:0]    fn_cmd;
    logic [7:0]     din_pin;
    logic [15:0]    func_in;
    logic [7:0]     din_eff_q;
    logic [7:0]     dout_q;
    logic [7:0]     isig_q;
    logic [7:0]     load_on;
    int             num_errors;
    int             cmp_count;
    row_t           rows [8];
    dsl_pkg::slot_t s;
    logic [31:0]    v;
    logic           x;
    logic           y;
    logic           r;

    dsl_matrix DUT (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .din_pin(din_pin),
        .func_in(func_in), .din_eff_q(din_eff_q), .dout_q(dout_q), .isig_q(isig_q));

    field_side field (.sw_cmd(sw_cmd), .fn_cmd(fn_cmd), .load_drv(dout_q),
        .din_pin(din_pin), .func_in(func_in), .load_on(load_on));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rdata_q;
    endtask

    task automatic put_slot(input logic [7:0] a, input logic [2:0] m, input logic [2:0] f,
                            input logic [4:0] s2, input logic [4:0] s1, input logic [4:0] d);
        s = '{inv2: m[2], inv1: m[1], invr: m[0], fn: f, src2: s2, src1: s1, dst: d};
        wr(a, 32'(s));
    endtask

    // Internal-to-internal hops add a cycle, so three edges cover every path used here
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        give_verdict;
    end

    initial
    begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        sw_cmd = 8'h00;
        fn_cmd = 16'h0000;
        num_errors = 0;
        cmp_count = 0;
        rows[0] = '{8'h00, 32'h0000_0006, 8'hf1, 16'h0000, 8'hf2, 8'h00, 8'h00};
        rows[1] = '{8'h00, 32'h0000_ffff, 8'h3c, 16'h0000, 8'h3c, 8'h00, 8'h00};
        rows[2] = '{8'h08, 32'h7654_3210, 8'h00, 16'h00a5, 8'h00, 8'ha5, 8'hff};
        rows[3] = '{8'h04, 32'h0000_0039, 8'h00, 16'h00a5, 8'h00, 8'ha1, 8'hff};
        rows[4] = '{8'h10, 32'hfedc_ba98, 8'h00, 16'h5a00, 8'h00, 8'h05, 8'h5a};
        rows[5] = '{8'h0c, 32'h0000_0039, 8'h00, 16'h5a00, 8'h00, 8'h05, 8'h59};
        rows[6] = '{8'h04, 32'h0000_0000, 8'h00, 16'h0000, 8'h00, 8'h00, 8'h01};
        rows[7] = '{8'h0c, 32'h0000_0000, 8'h00, 16'h0000, 8'h00, 8'h00, 8'h00};
        repeat (9) @(posedge clk_sys);
        #1;
        chk({8'h00, isig_q, dout_q, din_eff_q}, 32'h0);
        @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            rd(8'(4 * i), v);
            chk(v, 32'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(rows[i].a, rows[i].d);
            sw_cmd <= rows[i].din;
            fn_cmd <= rows[i].fn;
            settle;
            chk(32'(din_eff_q), 32'(rows[i].ee));
            chk(32'(load_on), 32'(rows[i].eo));
            chk(32'(isig_q), 32'(rows[i].ei));
        end
        for (int f = 1; f < 5; f++)
            for (int m = 0; m < 8; m++)
                for (int ab = 0; ab < 4; ab++)
                begin
                    put_slot(8'h20, 3'(m), 3'(f), 5'h02, 5'h01, 5'h01);
                    sw_cmd <= 8'(ab);
                    settle;
                    x = ab[0] ^ m[1];
                    y = ab[1] ^ m[2];
                    r = (f == 1) ? (x & y) : (f == 2) ? (x | y) : (f == 3) ? (x ^ y) : !x;
                    chk(32'(dout_q), 32'(r ^ m[0]));
                end
        put_slot(8'h20, 3'h0, dsl_pkg::F_AND, 5'h02, 5'h01, dsl_pkg::SEL_NONE);
        sw_cmd <= 8'h03;
        settle;
        chk(32'(dout_q), 32'h0);
        // Result negate set, so a slot that wrongly stays on would show a one
        put_slot(8'h20, 3'h1, dsl_pkg::F_NONE, 5'h02, 5'h01, dsl_pkg::SEL_DIO);
        settle;
        chk(32'(dout_q), 32'h0);
        put_slot(8'h20, 3'h1, 3'h7, 5'h02, 5'h01, dsl_pkg::SEL_DIO);
        settle;
        chk(32'(dout_q), 32'h0);
        put_slot(8'h20, 3'h4, dsl_pkg::F_OR, dsl_pkg::SEL_NONE, 5'h01, dsl_pkg::SEL_DIO);
        sw_cmd <= 8'h02;
        settle;
        chk(32'(dout_q), 32'h0);
        put_slot(8'h20, 3'h0, dsl_pkg::F_NOT, dsl_pkg::SEL_NONE, 5'h01, dsl_pkg::SEL_IS);
        sw_cmd <= 8'h00;
        put_slot(8'h24, 3'h0, dsl_pkg::F_XOR, 5'h01, dsl_pkg::SEL_IS, 5'h02);
        settle;
        chk({16'h0, isig_q, dout_q}, 32'h0000_0102);
        rd(dsl_pkg::A_STATE, v);
        chk(v, 32'h0001_0200);
        @(posedge clk_sys);
        #1;
        chk(rdata_q, 32'h0);
        @(posedge clk_sys);
        sw_cmd <= 8'h80;
        @(posedge clk_sys);
        #1;
        chk(32'(din_eff_q), 32'h80);
        rd(dsl_pkg::A_DIN_PIN, v);
        chk(v, 32'h80);
        wr(8'h30, 32'hffff_ffff);
        rd(8'h30, v);
        chk(v, 32'h0);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({8'h00, isig_q, dout_q, din_eff_q}, 32'h0);
        @(posedge clk_sys);
        resetn <= 1'b1;
        rd(8'h24, v);
        chk(v, 32'h0);
        wr(8'h21, 32'hffff_ffff);
        rd(8'h20, v);
        chk(v, 32'h0);
        give_verdict;
    end
endmodule
